/* File: hw/ees_entry.sv */
// exception entry unit: machine-state word, enable checks, drain, save and vector
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module ees_entry #(
  parameter bit HAS_XWIDE = 1'b1,
  parameter bit HAS_PMK   = 1'b1,
  parameter bit HAS_END   = 1'b1
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone classic slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // pipeline side
  input  wire ees_pkg::ees_req_s     exc_req_i,
  input  wire logic                  older_busy_i,
  input  wire logic [63:0]           next_pc_i,
  output logic                       req_ack_o,
  output logic                       fetch_stop_o,
  output ees_pkg::ees_redirect_s     redirect_o,
  output logic                       exc_taken_o,
  // interrupt and condition sources
  input  wire logic                  ext_irq_i,
  input  wire logic                  dec_irq_i,
  input  wire logic                  mchk_i,
  input  wire logic                  sreset_i,
  // machine-state view
  output logic      [63:0]           msw_o,
  output logic                       instr_translate_on_o,
  output logic                       data_translate_on_o,
  output logic                       endian_mode_o,
  output logic                       wide_mode_o,
  output logic                       perf_mark_o,
  output logic                       recoverable_flag_o,
  output logic                       checkstop_o
);

  // all flops live in one state word s;
  // next_s is built in one process.

  // package bit positions count from the
  // lsb: word bit k sits at position 63-k.

  // sequence: idle, drain, save, idle;
  // checkstop is left by system reset only.

  // a request is acked in the idle cycle
  // that takes it; outside idle it waits.

  // drain lasts while older work may fault;
  // save is a single cycle.

  // the redirect follows save by a cycle:
  // entry takes three cycles at the least.

  // fetch_stop_o falls in the redirect cycle,
  // when the new state is already in place.

  // interrupt levels are not latched, so no
  // stale pending flag can survive an entry.

  // a source dropped before it is taken is
  // lost; its owner must hold it high.

  // an ieee trap with fp modes clear is acked
  // and dropped, never queued for later.

  // idle priority: system reset, machine
  // check, precise request, external, decr.

  // precise requests beat interrupts so that
  // program order is kept.

  // entry overrides a same-cycle bus write;
  // software should not race an entry.

  // machine-state writes are masked, so bits
  // that are not implemented read zero.

  // the saved-state word is unmasked since it
  // holds status bits of its own.

  // the fault address loads only when the
  // request carries one.

  // vectors sit at base + (kind + 1) * step;
  // the base moves them all as one block.

  // reservations have no port; entry never
  // touches them.

  // only a machine check drops the machine-check
  // enable, so a nested one ends in checkstop.

  // the bus acks one cycle after taking a
  // request and drops ack a cycle later.

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    ees_pkg::ees_state_e st;
    logic [63:0]         msw;
    logic [63:0]         ssw;
    logic [63:0]         ras;
    logic [63:0]         fda;
    logic [31:0]         vbase;
    ees_pkg::ees_kind_e  kind;
    logic [63:0]         c_ras;
    logic [9:0]          c_stat;
    logic                c_fvalid;
    logic [63:0]         c_faddr;
    logic                ack;
    logic [31:0]         dat;
    logic                taken;
    ees_pkg::ees_redirect_s redir;
  } ees_entry_s;

  ees_entry_s s;
  ees_entry_s next_s;

  // implemented bits; the rest read as zero and ignore writes
  localparam logic [63:0] MSW_MASK = ees_pkg::MSW_CORE_MASK
      | (HAS_XWIDE ? ees_pkg::MSW_XWIDE_BIT : 64'h0)
      | (HAS_PMK   ? ees_pkg::MSW_PMK_BIT   : 64'h0)
      | (HAS_END   ? ees_pkg::MSW_END_BIT   : 64'h0);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge of a 32-bit bus write
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // machine state that the handler starts under
  function automatic logic [63:0] entry_msw(input logic [63:0] m,
                                            input logic        mcheck);
    logic [63:0] r;
    r = m;
    r[ees_pkg::WIDE_POS] = HAS_XWIDE ? m[ees_pkg::XWIDE_POS] : 1'b1;
    r[ees_pkg::POW_POS]  = 1'b0;
    r[ees_pkg::AIE_POS]  = 1'b0;
    r[ees_pkg::PRIV_POS] = 1'b0;
    r[ees_pkg::FAV_POS]  = 1'b0;
    r[ees_pkg::FEL_POS]  = 1'b0;
    r[ees_pkg::FEH_POS]  = 1'b0;
    r[ees_pkg::STEP_POS] = 1'b0;
    r[ees_pkg::BTR_POS]  = 1'b0;
    r[ees_pkg::PMK_POS]  = 1'b0;
    r[ees_pkg::ITR_POS]  = 1'b0;
    r[ees_pkg::DTR_POS]  = 1'b0;
    r[ees_pkg::REC_POS]  = 1'b0;
    r[ees_pkg::END_POS]  = HAS_END ? m[ees_pkg::XEND_POS] : 1'b0;
    // only a machine check clears the machine-check enable MCE_POS, so a nested one checkstops
    if (mcheck) begin
      r[ees_pkg::MCE_POS] = 1'b0;
    end
    return r & MSW_MASK;
  endfunction : entry_msw

  ////////////////////////////////////////////////////////////////////////////
  // enable decisions

  logic fp_modes_on;
  logic sync_ok;
  logic sync_drop;
  logic async_ok;

  // ieee fp traps only count while either fp mode bit is set
  assign fp_modes_on = s.msw[ees_pkg::FEL_POS] | s.msw[ees_pkg::FEH_POS];
  assign sync_drop   = exc_req_i.valid & exc_req_i.fp_ieee
                     & (exc_req_i.kind == ees_pkg::EES_K_PROGRAM)
                     & ~fp_modes_on;
  assign sync_ok     = exc_req_i.valid & ~sync_drop;
  // external and decrementer wait while the async enable is low
  assign async_ok    = s.msw[ees_pkg::AIE_POS] & (ext_irq_i | dec_irq_i);

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    next_s           = s;
    next_s.ack       = 1'b0;
    next_s.taken     = 1'b0;
    next_s.redir.valid = 1'b0;
    req_ack_o        = 1'b0;

    // bus: one-wait-state classic slave, ack drops the cycle after it rose
    if (wb_cyc_i && wb_stb_i && !s.ack) begin
      next_s.ack = 1'b1;
      case (wb_adr_i & 8'hFC)
        ees_pkg::MSW_LO_OFS: next_s.dat = s.msw[31:0];
        ees_pkg::MSW_HI_OFS: next_s.dat = s.msw[63:32];
        ees_pkg::SSW_LO_OFS: next_s.dat = s.ssw[31:0];
        ees_pkg::SSW_HI_OFS: next_s.dat = s.ssw[63:32];
        ees_pkg::RAS_LO_OFS: next_s.dat = s.ras[31:0];
        ees_pkg::RAS_HI_OFS: next_s.dat = s.ras[63:32];
        ees_pkg::FDA_LO_OFS: next_s.dat = s.fda[31:0];
        ees_pkg::FDA_HI_OFS: next_s.dat = s.fda[63:32];
        ees_pkg::VBASE_OFS:  next_s.dat = s.vbase;
        ees_pkg::STAT_OFS:   next_s.dat = {26'h0, s.kind, s.st};
        default:             next_s.dat = 32'h0;
      endcase
      if (wb_we_i) begin
        case (wb_adr_i & 8'hFC)
          ees_pkg::MSW_LO_OFS:
            next_s.msw[31:0] = merge(s.msw[31:0], wb_dat_i, wb_sel_i) & MSW_MASK[31:0];
          ees_pkg::MSW_HI_OFS:
            next_s.msw[63:32] = merge(s.msw[63:32], wb_dat_i, wb_sel_i)
                              & MSW_MASK[63:32];
          ees_pkg::SSW_LO_OFS: next_s.ssw[31:0]  = merge(s.ssw[31:0], wb_dat_i, wb_sel_i);
          ees_pkg::SSW_HI_OFS: next_s.ssw[63:32] = merge(s.ssw[63:32], wb_dat_i, wb_sel_i);
          ees_pkg::RAS_LO_OFS: next_s.ras[31:0]  = merge(s.ras[31:0], wb_dat_i, wb_sel_i);
          ees_pkg::RAS_HI_OFS: next_s.ras[63:32] = merge(s.ras[63:32], wb_dat_i, wb_sel_i);
          ees_pkg::FDA_LO_OFS: next_s.fda[31:0]  = merge(s.fda[31:0], wb_dat_i, wb_sel_i);
          ees_pkg::FDA_HI_OFS: next_s.fda[63:32] = merge(s.fda[63:32], wb_dat_i, wb_sel_i);
          ees_pkg::VBASE_OFS:  next_s.vbase      = merge(s.vbase, wb_dat_i, wb_sel_i);
          default: ;
        endcase
      end
    end

    // exception sequencing; hardware updates below override a same-cycle bus write
    case (s.st)
      ees_pkg::EES_IDLE: begin
        // priority: system reset, machine check, oldest precise, external, decrementer
        if (sreset_i) begin
          next_s.st       = ees_pkg::EES_DRAIN;
          next_s.kind     = ees_pkg::EES_K_SRESET;
          next_s.c_ras    = next_pc_i;
          next_s.c_stat   = 10'h000;
          next_s.c_fvalid = 1'b0;
        end else if (mchk_i) begin
          next_s.kind     = ees_pkg::EES_K_MCHECK;
          next_s.c_ras    = next_pc_i;
          next_s.c_stat   = 10'h000;
          next_s.c_fvalid = 1'b0;
          // disabled machine check goes straight to checkstop
          next_s.st = s.msw[ees_pkg::MCE_POS] ? ees_pkg::EES_DRAIN
                                              : ees_pkg::EES_CSTOP;
        end else if (sync_ok) begin
          req_ack_o       = 1'b1;
          next_s.st       = ees_pkg::EES_DRAIN;
          next_s.kind     = exc_req_i.kind;
          next_s.c_ras    = exc_req_i.resume_addr;
          next_s.c_stat   = exc_req_i.status;
          next_s.c_fvalid = exc_req_i.fault_valid;
          next_s.c_faddr  = exc_req_i.fault_addr;
        end else if (sync_drop) begin
          req_ack_o = 1'b1;
        end else if (async_ok) begin
          next_s.st       = ees_pkg::EES_DRAIN;
          next_s.kind     = ext_irq_i ? ees_pkg::EES_K_EXT : ees_pkg::EES_K_DECR;
          next_s.c_ras    = next_pc_i;
          next_s.c_stat   = 10'h000;
          next_s.c_fvalid = 1'b0;
        end
      end
      ees_pkg::EES_DRAIN: begin
        // fetch is held; wait for older work to be past any fault
        if (!older_busy_i) begin
          next_s.st = ees_pkg::EES_SAVE;
        end
      end
      ees_pkg::EES_SAVE: begin
        next_s.ras = s.c_ras;
        next_s.ssw = (s.msw & ees_pkg::SAVE_COPY_MASK)
                   | {33'h0, s.c_stat[9:6], 5'h0, s.c_stat[5:0], 16'h0};
        if (s.c_fvalid) begin
          next_s.fda = s.c_faddr;
        end
        // reservations are not touched here; the pipeline keeps them
        next_s.msw = entry_msw(s.msw, s.kind == ees_pkg::EES_K_MCHECK);
        next_s.redir.valid = 1'b1;
        next_s.redir.addr  = {32'h0, s.vbase}
                           + (64'(s.kind) + 64'h1) * ees_pkg::VEC_STEP;
        next_s.taken = 1'b1;
        next_s.st    = ees_pkg::EES_IDLE;
      end
      ees_pkg::EES_CSTOP: begin
        // halted for good; only a system reset restarts the machine
        if (sreset_i) begin
          next_s.st       = ees_pkg::EES_DRAIN;
          next_s.kind     = ees_pkg::EES_K_SRESET;
          next_s.c_ras    = next_pc_i;
          next_s.c_stat   = 10'h000;
          next_s.c_fvalid = 1'b0;
        end
      end
      default: next_s.st = ees_pkg::EES_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s          <= '0;
      s.st       <= ees_pkg::EES_IDLE;
      s.msw      <= ees_pkg::MSW_RESET;
      s.vbase    <= ees_pkg::VBASE_RESET;
      s.kind     <= ees_pkg::EES_K_SRESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // fetch stays stopped through drain, save and checkstop
  assign fetch_stop_o = (s.st != ees_pkg::EES_IDLE);
  assign checkstop_o  = (s.st == ees_pkg::EES_CSTOP);
  assign redirect_o   = s.redir;
  assign exc_taken_o  = s.taken;
  assign wb_ack_o     = s.ack;
  assign wb_dat_o     = s.dat;

  // live machine-state fields; translation follows the bits directly
  assign msw_o                = s.msw;
  assign instr_translate_on_o = s.msw[ees_pkg::ITR_POS];
  assign data_translate_on_o  = s.msw[ees_pkg::DTR_POS];
  assign perf_mark_o          = s.msw[ees_pkg::PMK_POS];
  assign recoverable_flag_o   = s.msw[ees_pkg::REC_POS];
  assign endian_mode_o        = s.msw[ees_pkg::END_POS];
  assign wide_mode_o          = s.msw[ees_pkg::WIDE_POS];

endmodule : ees_entry

`default_nettype wire

/* File: hw/ees_pkg.sv */
// constants, types and register map of the exception entry unit
package ees_pkg;

  // machine-state bit positions, counted from the lsb (word bit 0 is bit 63 here)
  localparam int WIDE_POS   = 63;
  localparam int XWIDE_POS  = 61;
  localparam int POW_POS    = 18;
  localparam int XEND_POS   = 16;
  localparam int AIE_POS    = 15;
  localparam int PRIV_POS   = 14;
  localparam int FAV_POS    = 13;
  localparam int MCE_POS    = 12;
  localparam int FEL_POS    = 11;
  localparam int STEP_POS   = 10;
  localparam int BTR_POS    = 9;
  localparam int FEH_POS    = 8;
  localparam int ITR_POS    = 5;
  localparam int DTR_POS    = 4;
  localparam int PMK_POS    = 2;
  localparam int REC_POS    = 1;
  localparam int END_POS    = 0;

  // bits that always exist in the machine-state word; options are added on top
  localparam logic [63:0] MSW_CORE_MASK = 64'h8000_0000_0005_FF32;
  localparam logic [63:0] MSW_XWIDE_BIT = 64'h2000_0000_0000_0000;
  localparam logic [63:0] MSW_PMK_BIT   = 64'h0000_0000_0000_0004;
  localparam logic [63:0] MSW_END_BIT   = 64'h0000_0000_0000_0001;
  localparam logic [63:0] MSW_RESET     = 64'h8000_0000_0000_0000;

  // saved-state word: copied machine-state bits and exception status bits
  localparam logic [63:0] SAVE_COPY_MASK = 64'hFFFF_FFFF_87C0_FFFF;
  localparam int          STAT_A_LSB     = 27;
  localparam int          STAT_B_LSB     = 16;

  // vector spacing; vector = base + (kind + 1) * step
  localparam logic [63:0] VEC_STEP = 64'h0000_0000_0000_0100;

  // wishbone register byte offsets
  localparam logic [7:0] MSW_LO_OFS = 8'h00;
  localparam logic [7:0] MSW_HI_OFS = 8'h04;
  localparam logic [7:0] SSW_LO_OFS = 8'h08;
  localparam logic [7:0] SSW_HI_OFS = 8'h0C;
  localparam logic [7:0] RAS_LO_OFS = 8'h10;
  localparam logic [7:0] RAS_HI_OFS = 8'h14;
  localparam logic [7:0] FDA_LO_OFS = 8'h18;
  localparam logic [7:0] FDA_HI_OFS = 8'h1C;
  localparam logic [7:0] VBASE_OFS  = 8'h20;
  localparam logic [7:0] STAT_OFS   = 8'h24;
  localparam logic [31:0] VBASE_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    EES_K_SRESET  = 4'h0,
    EES_K_MCHECK  = 4'h1,
    EES_K_DSTORE  = 4'h2,
    EES_K_DSEG    = 4'h3,
    EES_K_ISTORE  = 4'h4,
    EES_K_ISEG    = 4'h5,
    EES_K_EXT     = 4'h6,
    EES_K_ALIGN   = 4'h7,
    EES_K_PROGRAM = 4'h8,
    EES_K_FPUNAV  = 4'h9,
    EES_K_DECR    = 4'hA,
    EES_K_SYSCALL = 4'hB,
    EES_K_TRACE   = 4'hC,
    EES_K_PERFMON = 4'hD
  } ees_kind_e;

  typedef enum logic [1:0] {
    EES_IDLE  = 2'h0,
    EES_DRAIN = 2'h1,
    EES_SAVE  = 2'h2,
    EES_CSTOP = 2'h3
  } ees_state_e;

  // oldest precise exception offered by the pipeline
  typedef struct packed {
    logic        valid;
    ees_kind_e   kind;
    logic        fp_ieee;
    logic [63:0] resume_addr;
    logic [9:0]  status;
    logic        fault_valid;
    logic [63:0] fault_addr;
  } ees_req_s;

  typedef struct packed {
    logic        valid;
    logic [63:0] addr;
  } ees_redirect_s;

endpackage : ees_pkg

/* File: tb/ees_entry_assertions.sv */
// port assertions of the exception entry unit and their bind
`timescale 1ns/1ps
`default_nettype none
module ees_entry_chk (
  // clock and reset
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  // wishbone and sources
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_ack_o,
  input wire logic                   older_busy_i,
  input wire logic                   sreset_i,
  // pipeline side
  input wire logic                   fetch_stop_o,
  input wire ees_pkg::ees_redirect_s redirect_o,
  input wire logic                   exc_taken_o,
  input wire logic                   checkstop_o,
  // machine-state view
  input wire logic [63:0]            msw_o,
  input wire logic                   instr_translate_on_o,
  input wire logic                   data_translate_on_o,
  input wire logic                   endian_mode_o,
  input wire logic                   wide_mode_o,
  input wire logic                   perf_mark_o,
  input wire logic                   recoverable_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // single-bit views other than wide mode must follow the word, else translation and byte order drift
  msw_view_a: assert property (instr_translate_on_o == msw_o[ees_pkg::ITR_POS]
    && data_translate_on_o == msw_o[ees_pkg::DTR_POS] && endian_mode_o == msw_o[ees_pkg::END_POS]
    && perf_mark_o == msw_o[ees_pkg::PMK_POS] && recoverable_flag_o == msw_o[ees_pkg::REC_POS])
    else $error("machine-state view bit differs from word");
  taken_pair_a: assert property (redirect_o.valid == exc_taken_o)
    else $error("redirect and taken pulse disagree");
  // new state on entry: translation, async enable, privilege, fp, trace, mark, recovery all clear
  entry_clear_a: assert property (exc_taken_o |-> (msw_o & 64'h0000_0000_0004_EF36) == 64'h0)
    else $error("entry left a cleared bit set");
  entry_mode_a: assert property (exc_taken_o |-> wide_mode_o == msw_o[ees_pkg::XWIDE_POS]
    && endian_mode_o == msw_o[ees_pkg::XEND_POS]) else $error("entry mode bits not copied");
  xwide_keep_a: assert property (exc_taken_o |-> $stable(msw_o[ees_pkg::XWIDE_POS]))
    else $error("exception wide bit altered by entry");
  // first drain cycle with older work busy must not move on
  drain_wait_a: assert property (fetch_stop_o && !$past(fetch_stop_o) && older_busy_i
    && !checkstop_o |=> fetch_stop_o && !exc_taken_o) else $error("drain ended while busy");
  stop_release_a: assert property (exc_taken_o |-> !fetch_stop_o && $past(fetch_stop_o))
    else $error("redirect without a preceding stop");
  cstop_hold_a: assert property (checkstop_o && !sreset_i |=> checkstop_o)
    else $error("checkstop left without system reset");
  cstop_halt_a: assert property (checkstop_o |-> fetch_stop_o && !exc_taken_o)
    else $error("fetch running in checkstop");
  wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not one cycle after request");
  cover_entry_c: cover property (exc_taken_o);
  cover_cstop_c: cover property (checkstop_o ##1 !checkstop_o);
  cover_drain_c: cover property (fetch_stop_o && older_busy_i ##1 fetch_stop_o);
endmodule : ees_entry_chk

bind ees_entry ees_entry_chk i_ees_entry_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .older_busy_i, .sreset_i, .fetch_stop_o, .redirect_o, .exc_taken_o, .checkstop_o, .msw_o,
  .instr_translate_on_o, .data_translate_on_o, .endian_mode_o, .wide_mode_o, .perf_mark_o,
  .recoverable_flag_o);
`default_nettype wire

/* File: tb/ees_pipe_model.sv */
// pipeline model: offers one precise exception and holds older work busy
`timescale 1ns/1ps
`default_nettype none
module ees_pipe_model (
  // clock, reset and bench control
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              start_i,
  input  wire ees_pkg::ees_req_s req_i,
  input  wire logic [3:0]        busy_n_i,
  // unit side
  input  wire logic              req_ack_i,
  input  wire logic              fetch_stop_i,
  output ees_pkg::ees_req_s      exc_req_o,
  output logic                   older_busy_o
);
  logic [3:0] busy_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // request held until accepted; then scrambled so stale fields cannot pass as valid
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exc_req_o <= '0;
      busy_cnt  <= 4'h0;
    end else if (start_i) begin
      exc_req_o <= req_i;
      busy_cnt  <= busy_n_i;
    end else begin
      if (req_ack_i && exc_req_o.valid)
        exc_req_o <= ees_pkg::ees_req_s'({1'b0, ~exc_req_o[$bits(exc_req_o)-2:0]});
      if (fetch_stop_i && busy_cnt != 4'h0)
        busy_cnt <= busy_cnt - 4'h1;
    end
  end
  // busy whenever fetch runs; in a drain only for the programmed count
  assign older_busy_o = !fetch_stop_i || (busy_cnt != 4'h0);
endmodule : ees_pipe_model
`default_nettype wire

/* File: tb/tb_ees_entry.sv */
// self-checking bench of the exception entry unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_ees_entry;
  typedef struct packed {
    logic [2:0]  src;
    logic [3:0]  kind;
    logic        fp;
    logic [63:0] msw;
    logic [9:0]  st;
    logic [3:0]  busy;
  } ees_row_s;
  localparam logic [63:0] MSK = ees_pkg::MSW_CORE_MASK | ees_pkg::MSW_XWIDE_BIT
                                | ees_pkg::MSW_PMK_BIT | ees_pkg::MSW_END_BIT;
  localparam logic [63:0] CLR = 64'h0000_0000_0004_EF36;
  localparam logic [63:0] RES = 64'h0000_0000_0001_2340;
  localparam logic [63:0] NPC = 64'h0000_0000_0000_ABC0;
  localparam logic [31:0] VB  = 32'h0004_0000;
  // src 0 pipeline, 1 external, 2 decrementer, 3 machine check, 4 system reset
  localparam ees_row_s ROWS [7] = '{'{3'h0, 4'h2, 1'b0, 64'hA000_0000_0005_FF37, 10'h3FF, 4'h0},
    '{3'h0, 4'hB, 1'b0, 64'h8000_0000_0000_8031, 10'h2A5, 4'h3},
    '{3'h0, 4'h8, 1'b1, 64'h0000_0000_0000_0904, 10'h155, 4'h1},
    '{3'h1, 4'h6, 1'b0, 64'h2000_0000_0001_8034, 10'h000, 4'h0},
    '{3'h2, 4'hA, 1'b0, 64'h0000_0000_0000_9002, 10'h000, 4'h0},
    '{3'h3, 4'h1, 1'b0, 64'hA000_0000_0000_1030, 10'h000, 4'h0},
    '{3'h4, 4'h0, 1'b0, 64'h8000_0000_0000_7F33, 10'h000, 4'h0}};
  localparam logic [3:0] KS [7] = '{4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hC, 4'hD};
  logic clk_i, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, start = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0, busy_n = 4'h0, irq = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [63:0] next_pc_i = NPC, msw_o;
  logic wb_ack_o, older_busy, req_ack_o, fetch_stop_o, exc_taken_o, checkstop_o;
  logic itr, dtr, endm, wide, pmk, rec;
  ees_pkg::ees_req_s      req = '0, exc_req;
  ees_pkg::ees_redirect_s redirect_o;
  int fails = 0, samples_checked = 0;
  ees_entry i_ees_entry (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .exc_req_i(exc_req), .older_busy_i(older_busy),
    .next_pc_i(next_pc_i), .req_ack_o(req_ack_o), .fetch_stop_o(fetch_stop_o),
    .redirect_o(redirect_o), .exc_taken_o(exc_taken_o), .ext_irq_i(irq[0]), .dec_irq_i(irq[1]),
    .mchk_i(irq[2]), .sreset_i(irq[3]), .msw_o(msw_o), .instr_translate_on_o(itr),
    .data_translate_on_o(dtr), .endian_mode_o(endm), .wide_mode_o(wide), .perf_mark_o(pmk),
    .recoverable_flag_o(rec), .checkstop_o(checkstop_o));
  ees_pipe_model i_ees_pipe_model (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .req_i(req),
    .busy_n_i(busy_n), .req_ack_i(req_ack_o), .fetch_stop_i(fetch_stop_o), .exc_req_o(exc_req),
    .older_busy_o(older_busy));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog; the run needs well under 5000 cycles
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    end_sim();
  end
  // classic wishbone cycle: held until ack is sampled, released after it
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hF, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask : wr
  task automatic rd64(input logic [7:0] a, output logic [63:0] v);
    wb(a, 1'b0, 32'h0, v[31:0]);
    wb(a + 8'h04, 1'b0, 32'h0, v[63:32]);
  endtask : rd64
  // expected state after entry, worked out independently of the unit
  function automatic logic [63:0] exp_msw(input logic [63:0] o, input logic mc);
    logic [63:0] e;
    e = o & ~CLR;
    e[ees_pkg::WIDE_POS] = o[ees_pkg::XWIDE_POS];
    e[ees_pkg::END_POS] = o[ees_pkg::XEND_POS];
    if (mc) e[ees_pkg::MCE_POS] = 1'b0;
    return e;
  endfunction : exp_msw
  // one entry: load state, raise the source, wait for redirect, check saved state
  task automatic run_row(input ees_row_s r);
    logic [63:0] m, v, e;
    logic [5:0]  ev;
    int n;
    m = r.msw & MSK;
    wr(ees_pkg::MSW_LO_OFS, m[31:0]);
    wr(ees_pkg::MSW_HI_OFS, m[63:32]);
    @(posedge clk_i);
    `CHK("msw_write", m, msw_o)
    if (r.src == 3'h0) begin
      req <= '{1'b1, ees_pkg::ees_kind_e'(r.kind), r.fp, RES, r.st, 1'b1, RES};
      busy_n <= r.busy;
      start <= 1'b1;
    end else irq <= 4'h1 << (r.src - 3'h1);
    n = 0;
    do begin
      @(posedge clk_i);
      start <= 1'b0;
      if (fetch_stop_o === 1'b1) irq <= 4'h0; // async sources held until taken
      n++;
    end while (exc_taken_o !== 1'b1 && n < 50);
    `CHK("vector", {32'h0, VB} + (r.kind + 64'h1) * ees_pkg::VEC_STEP, redirect_o.addr)
    e = exp_msw(m, r.src == 3'h3);
    ev = {e[ees_pkg::ITR_POS], e[ees_pkg::DTR_POS], e[ees_pkg::END_POS],
          e[ees_pkg::WIDE_POS], e[ees_pkg::PMK_POS], e[ees_pkg::REC_POS]};
    `CHK("msw_entry", e, msw_o)
    `CHK("views", ev, {itr, dtr, endm, wide, pmk, rec})
    rd64(ees_pkg::SSW_LO_OFS, v);
    `CHK("ssw_copy", m & ees_pkg::SAVE_COPY_MASK, v & ees_pkg::SAVE_COPY_MASK)
    if (r.src == 3'h0)
      `CHK("ssw_status", r.st, {v[ees_pkg::STAT_A_LSB +: 4], v[ees_pkg::STAT_B_LSB +: 6]})
    rd64(ees_pkg::RAS_LO_OFS, v);
    `CHK("resume", (r.src == 3'h0) ? RES : NPC, v)
  endtask : run_row
  initial begin
    logic [63:0] v;
    int          n;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("msw_reset", ees_pkg::MSW_RESET, msw_o)
    rd64(ees_pkg::SSW_LO_OFS, v);
    `CHK("ssw_reset", 64'h0, v)
    wr(8'h30, 32'hFFFF_FFFF);
    rd64(8'h30, v);
    `CHK("unmapped", 64'h0, v)
    wb(ees_pkg::VBASE_OFS, 1'b0, 32'h0, v[31:0]);
    `CHK("vbase_reset", ees_pkg::VBASE_RESET, v[31:0])
    wr(ees_pkg::VBASE_OFS, VB);
    foreach (ROWS[i]) run_row(ROWS[i]);
    foreach (KS[i]) run_row('{3'h0, KS[i], 1'b0, 64'hA000_0000_0000_8030, 10'h0C3, 4'h2});
    // ieee trap with both fp modes clear, external and decrementer with enable clear
    wr(ees_pkg::MSW_LO_OFS, 32'h0);
    wr(ees_pkg::MSW_HI_OFS, 32'h0);
    @(posedge clk_i);
    req <= '{1'b1, ees_pkg::EES_K_PROGRAM, 1'b1, RES, 10'h0, 1'b0, RES};
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    irq <= 4'h3;
    repeat (8) @(posedge clk_i);
    `CHK("fp_dropped", 1'b0, exc_req.valid)
    `CHK("no_entry", 1'b0, fetch_stop_o)
    // machine check with its enable clear stops the core until system reset
    irq <= 4'h4;
    n = 0;
    do begin @(posedge clk_i); n++; end while (checkstop_o !== 1'b1 && n < 20);
    irq <= 4'h0;
    repeat (10) @(posedge clk_i);
    `CHK("checkstop", 1'b1, checkstop_o)
    wb(ees_pkg::STAT_OFS, 1'b0, 32'h0, v[31:0]);
    `CHK("cstop_state", 2'h3, v[1:0])
    run_row('{3'h4, 4'h0, 1'b0, 64'h0, 10'h0, 4'h0});
    `CHK("cstop_left", 1'b0, checkstop_o)
    end_sim();
  end
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
endmodule : tb_ees_entry
`default_nettype wire
